/* File: hw/touch_cfg_params.svh */
`ifndef TOUCH_CFG_PARAMS_SVH
`define TOUCH_CFG_PARAMS_SVH
// ==========================================================================
// Register indices (byte map, also word index on the Avalon-MM side).
`define REG_CTRL 5'h00
`define REG_MODE 5'h01
`define REG_TOGGLE 5'h02
`define REG_BTOUCH 5'h03
`define REG_LASTBTN 5'h04
`define REG_ONTIME 5'h05
`define REG_LED_ZERO 5'h10
`define REG_LED_G1 5'h11
`define REG_LED_G2 5'h14
`define REG_LED_G3 5'h17
`define REG_LED_END 5'h19
`define REG_CUR_LO 5'h1A
`define REG_CUR_HI 5'h1B
`define REG_LAT_LO 5'h1C
`define REG_LAT_HI 5'h1D
`define REG_DIAG 5'h1E
`define REG_HOST_OUT 5'h1F
// ==========================================================================
// Values and timing.
`define REG_RESET_VAL 8'h00
`define SAVE_CMD 8'h1A
`define SLAVE_ADDR_DEF 7'h37
`define SWRST_TIME_MS 350
`define CLK_MHZ 50
`define SWRST_CYCLES (`SWRST_TIME_MS * 1000 * `CLK_MHZ)
`endif

/* File: hw/touch_cfg_pkg.sv */
`default_nettype none
package touch_cfg_pkg;
    // ======================================================================
    // Serial slave states.
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_RD, ST_MACK
    } i2c_state_e;
    // Effective LED feature enables after the interlocks.
    typedef struct packed {
        logic [3:0] ontime_eff;
        logic last_btn_eff;
    } led_eff_s;
endpackage
`default_nettype wire

/* File: hw/touch_ctrl_i2c_config_access.sv */
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`include "touch_cfg_params.svh"
`default_nettype none
module touch_ctrl_i2c_config_access #(
    parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEF,
    parameter int SWRST_CYCLES = `SWRST_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Serial link pins, open drain data.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Avalon-MM register slave.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Sensing core status, same clock.
    input wire logic [9:0] touch_in,
    input wire logic [7:0] diag_in,
    // Outputs.
    output logic [9:0] led_out,
    output logic [7:0] host_out,
    output touch_cfg_pkg::led_eff_s eff_out,
    output logic swrst_busy
);
    logic [7:0] mem [0:31];
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    touch_cfg_pkg::i2c_state_e state_r;
    logic [7:0] shift_r, tx_r, i2c_wd_r;
    logic [4:0] ptr_r, i2c_wa_r;
    logic [2:0] bit_cnt_r;
    logic rw_r, first_r, phase_r, oe_r, i2c_we_r;
    logic [24:0] rst_cnt_r;
    logic rst_end;
    logic done_r, av_acc, av_we;
    logic [4:0] av_idx;
    logic wr_en, save_hit;
    logic [4:0] wr_a;
    logic [7:0] wr_d;
    logic [9:0] latch_r, touch_d_r, led_r;
    logic [3:0] last_idx_r;
    logic [3:0] toggle_en;
    logic start_c, stop_c, rise_c, fall_c;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;

    // ======================================================================
    // Helpers.
    // Folds every member of an LED group onto the group's single register.
    function automatic logic [4:0] map_idx(input logic [4:0] a);
        if (a >= `REG_LED_G1 && a < `REG_LED_G2) begin
            return `REG_LED_G1;
        end else if (a >= `REG_LED_G2 && a < `REG_LED_G3) begin
            return `REG_LED_G2;
        end else if (a >= `REG_LED_G3 && a <= `REG_LED_END) begin
            return `REG_LED_G3;
        end
        return a;
    endfunction

    // Status bytes come straight from live state, never from saved config.
    function automatic logic [7:0] get_byte(input logic [4:0] a);
        case (a)
            `REG_CUR_LO: return touch_in[7:0];
            `REG_CUR_HI: return {6'h00, touch_in[9:8]};
            `REG_LAT_LO: return latch_r[7:0];
            `REG_LAT_HI: return {6'h00, latch_r[9:8]};
            `REG_DIAG: return diag_in;
            default: return mem[map_idx(a)];
        endcase
    endfunction

    // Output index to group number: 0, then 1..3, 4..6, 7..9.
    function automatic logic [1:0] grp(input int i);
        return 2'((i + 2) / 3);
    endfunction

    // ======================================================================
    // Pin synchronisers; the first stage feeds only the second.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
        end
    end

    // Bus conditions seen on the synchronised copies.
    assign start_c = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
    assign rise_c = scl_s & ~scl_d;
    assign fall_c = ~scl_s & scl_d;
    assign byte_in = {shift_r[6:0], sda_s};
    // Byte at the pointer, named so its bits can be sliced for the shifter.
    assign rd_byte = get_byte(ptr_r);
    assign sda_out = 1'b0;
    assign sda_oe = oe_r;

    // ======================================================================
    // Serial slave: bits are sampled on SCL rise and driven after SCL fall.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r <= touch_cfg_pkg::ST_IDLE;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 5'h00;
            bit_cnt_r <= 3'h0;
            rw_r <= 1'b0;
            first_r <= 1'b1;
            phase_r <= 1'b0;
            oe_r <= 1'b0;
            i2c_we_r <= 1'b0;
            i2c_wa_r <= 5'h00;
            i2c_wd_r <= 8'h00;
        end else begin
            i2c_we_r <= 1'b0;
            if (start_c) begin
                state_r <= touch_cfg_pkg::ST_ADDR;
                bit_cnt_r <= 3'h0;
                first_r <= 1'b1;
                phase_r <= 1'b0;
                oe_r <= 1'b0;
            end else if (stop_c) begin
                state_r <= touch_cfg_pkg::ST_IDLE;
                oe_r <= 1'b0;
            end else begin
                case (state_r)
                    touch_cfg_pkg::ST_ADDR: if (rise_c) begin
                        shift_r <= byte_in;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            // A busy device stays silent so the host retries.
                            if (shift_r[6:0] == SLAVE_ADDR && !swrst_busy) begin
                                rw_r <= sda_s;
                                ptr_r <= sda_s ? 5'h00 : ptr_r;
                                state_r <= touch_cfg_pkg::ST_ACK;
                            end else begin
                                state_r <= touch_cfg_pkg::ST_IDLE;
                            end
                        end
                    end
                    touch_cfg_pkg::ST_ACK: if (fall_c) begin
                        phase_r <= ~phase_r;
                        bit_cnt_r <= 3'h0;
                        if (!phase_r) begin
                            oe_r <= 1'b1;
                        end else if (rw_r) begin
                            tx_r <= {rd_byte[6:0], 1'b0};
                            oe_r <= ~rd_byte[7];
                            state_r <= touch_cfg_pkg::ST_RD;
                        end else begin
                            oe_r <= 1'b0;
                            state_r <= touch_cfg_pkg::ST_WR;
                        end
                    end
                    touch_cfg_pkg::ST_WR: if (rise_c) begin
                        shift_r <= byte_in;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            state_r <= touch_cfg_pkg::ST_ACK;
                            first_r <= 1'b0;
                            if (first_r) begin
                                ptr_r <= byte_in[4:0];
                            end else begin
                                i2c_we_r <= 1'b1;
                                i2c_wa_r <= ptr_r;
                                i2c_wd_r <= byte_in;
                                ptr_r <= ptr_r + 5'h01;
                            end
                        end
                    end
                    touch_cfg_pkg::ST_RD: begin
                        if (rise_c) begin
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == 3'h7) begin
                                state_r <= touch_cfg_pkg::ST_MACK;
                                phase_r <= 1'b0;
                            end
                        end else if (fall_c) begin
                            oe_r <= ~tx_r[7];
                            tx_r <= {tx_r[6:0], 1'b0};
                        end
                    end
                    touch_cfg_pkg::ST_MACK: begin
                        if (rise_c) begin
                            if (sda_s) begin
                                state_r <= touch_cfg_pkg::ST_IDLE;
                            end else begin
                                phase_r <= 1'b1;
                                ptr_r <= ptr_r + 5'h01;
                            end
                        end else if (fall_c) begin
                            if (phase_r) begin
                                phase_r <= 1'b0;
                                bit_cnt_r <= 3'h0;
                                tx_r <= {rd_byte[6:0], 1'b0};
                                oe_r <= ~rd_byte[7];
                                state_r <= touch_cfg_pkg::ST_RD;
                            end else begin
                                oe_r <= 1'b0;
                            end
                        end
                    end
                    default: oe_r <= 1'b0;
                endcase
            end
        end
    end

    // ======================================================================
    // Avalon-MM slave: one wait cycle; a serial write in the same cycle
    // holds the bus access off for another cycle.
    assign av_idx = avs_address[6:2];
    assign avs_waitrequest = (avs_read | avs_write) & ~(done_r & ~i2c_we_r & ~rst_end);
    assign av_acc = (avs_read | avs_write) & ~avs_waitrequest;
    assign av_we = av_acc & avs_write & ~avs_address[7];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            done_r <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            done_r <= (avs_read | avs_write) & ~av_acc;
            // Unmapped addresses read as zero.
            avs_readdata <= avs_address[7] ? 32'h0000_0000 : {24'h00_0000, get_byte(av_idx)};
        end
    end

    // ======================================================================
    // Shared write port and software reset sequencing.
    assign wr_en = i2c_we_r | av_we;
    assign wr_a = i2c_we_r ? i2c_wa_r : av_idx;
    assign wr_d = i2c_we_r ? i2c_wd_r : avs_writedata[7:0];
    assign save_hit = wr_en && wr_a == `REG_CTRL && wr_d == `SAVE_CMD;
    assign rst_end = swrst_busy && rst_cnt_r == 25'(SWRST_CYCLES - 1);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            swrst_busy <= 1'b0;
            rst_cnt_r <= 25'h0;
        end else if (save_hit && !swrst_busy) begin
            swrst_busy <= 1'b1;
            rst_cnt_r <= 25'h0;
        end else if (rst_end) begin
            swrst_busy <= 1'b0;
        end else if (swrst_busy) begin
            rst_cnt_r <= rst_cnt_r + 25'h1;
        end
    end

    // Configuration RAM; the reload at the end of the software reset clears
    // REG_CTRL and REG_HOST_OUT and leaves every other location unchanged.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) begin
                mem[i] <= `REG_RESET_VAL;
            end
        end else if (rst_end) begin
            mem[`REG_HOST_OUT] <= `REG_RESET_VAL;
            mem[`REG_CTRL] <= `REG_RESET_VAL;
        end else if (wr_en && (wr_a < `REG_CUR_LO || wr_a == `REG_HOST_OUT)) begin
            mem[map_idx(wr_a)] <= wr_d;
        end
    end

    // Latched touches; a new touch wins over a clear written in that cycle.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            latch_r <= 10'h000;
        end else begin
            latch_r <= (latch_r & ~({
                (wr_en && wr_a == `REG_LAT_HI) ? wr_d[1:0] : 2'h0,
                (wr_en && wr_a == `REG_LAT_LO) ? wr_d : 8'h00})) | touch_in;
        end
    end

    // ======================================================================
    // LED feature interlocks and output drive.
    assign toggle_en = mem[`REG_TOGGLE][3:0];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            eff_out <= '0;
            host_out <= 8'h00;
        end else begin
            eff_out.ontime_eff <= mem[`REG_ONTIME][3:0] & ~toggle_en
                & ~mem[`REG_BTOUCH][3:0];
            eff_out.last_btn_eff <= mem[`REG_LASTBTN][0] & ~|toggle_en;
            host_out <= mem[`REG_HOST_OUT];
        end
    end

    // Toggle outputs flip on a touch edge; otherwise follow touch or last.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            touch_d_r <= 10'h000;
            led_r <= 10'h000;
            last_idx_r <= 4'h0;
        end else begin
            touch_d_r <= touch_in;
            for (int i = 0; i < 10; i++) begin
                if (touch_in[i] && !touch_d_r[i]) begin
                    last_idx_r <= 4'(i);
                end
                if (toggle_en[grp(i)]) begin
                    led_r[i] <= led_r[i] ^ (touch_in[i] & ~touch_d_r[i]);
                end else if (eff_out.last_btn_eff) begin
                    led_r[i] <= (last_idx_r == 4'(i)) | touch_in[i];
                end else begin
                    led_r[i] <= touch_in[i];
                end
            end
        end
    end
    assign led_out = led_r;

    // ======================================================================
    // Checks.
    a_read_from_zero: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == touch_cfg_pkg::ST_ADDR && rise_c && bit_cnt_r == 3'h7 && sda_s
         && shift_r[6:0] == SLAVE_ADDR && !swrst_busy) |=> ptr_r == 5'h00)
        else $error("read did not start at location zero");
    a_pointer_byte_sets: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == touch_cfg_pkg::ST_WR && rise_c && bit_cnt_r == 3'h7 && first_r)
        |=> ptr_r == $past(byte_in[4:0]) && !i2c_we_r)
        else $error("first write byte did not set pointer");
    a_group_write_shared: assert property (@(posedge core_clk) disable iff (reset)
        (i2c_we_r && !rst_end && map_idx(i2c_wa_r) == `REG_LED_G2)
        |=> mem[`REG_LED_G2] == $past(i2c_wd_r))
        else $error("group member write missed shared register");
    a_save_clears_out: assert property (@(posedge core_clk) disable iff (reset)
        rst_end |=> !swrst_busy ##1 host_out == 8'h00)
        else $error("software reset left host outputs set");
    a_save_starts_reset: assert property (@(posedge core_clk) disable iff (reset)
        (save_hit && !swrst_busy) |=> swrst_busy)
        else $error("save command did not start reset");
    // A busy device must drop back to idle on its own address, never ACK it.
    a_busy_no_ack: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == touch_cfg_pkg::ST_ADDR && rise_c && bit_cnt_r == 3'h7 && swrst_busy)
        |=> state_r == touch_cfg_pkg::ST_IDLE && !oe_r)
        else $error("address acknowledged while busy");
    a_toggle_no_ontime: assert property (@(posedge core_clk) disable iff (reset)
        $past(toggle_en[0]) |-> !eff_out.ontime_eff[0])
        else $error("on-time active with toggle");
    a_btouch_no_ontime: assert property (@(posedge core_clk) disable iff (reset)
        $past(mem[`REG_BTOUCH][1]) |-> !eff_out.ontime_eff[1])
        else $error("on-time active with touch effect");
    a_toggle_no_last: assert property (@(posedge core_clk) disable iff (reset)
        $past(|toggle_en) |-> !eff_out.last_btn_eff)
        else $error("last-button effect active with toggle");
    a_status_read_live: assert property (@(posedge core_clk) disable iff (reset)
        (avs_read && avs_address == {1'b0, `REG_CUR_LO, 2'b00} && !avs_waitrequest)
        |-> avs_readdata[7:0] == $past(touch_in[7:0]))
        else $error("current status read returned stale data");
    c_i2c_write: cover property (@(posedge core_clk) disable iff (reset) i2c_we_r);
    c_i2c_read: cover property (@(posedge core_clk) disable iff (reset)
        state_r == touch_cfg_pkg::ST_MACK && phase_r);
    c_save_done: cover property (@(posedge core_clk) disable iff (reset) rst_end);
    c_av_read: cover property (@(posedge core_clk) disable iff (reset) av_acc && avs_read);
endmodule // touch_ctrl_i2c_config_access
`default_nettype wire

/* File: test/host_i2c_model.sv */
`include "touch_cfg_params.svh"
`default_nettype none
// ==========
// Host processor acting as serial bus master.
module host_i2c_model #(
    parameter logic [6:0] ADDR = `SLAVE_ADDR_DEF,
    parameter int HALF = 6,
    parameter int SCAN_GAP = 50,
    parameter int host_retry_cap = 20
) (
    // Clock and device pull-down.
    input wire logic core_clk,
    input wire logic sda_oe,
    // Bus lines as the device sees them.
    output var logic scl,
    output logic sda,
    // Bytes taken in during reads.
    output var logic rx_valid,
    output var logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sda_pull = 1'b0;
    // Start idle so the device sees no stray edge.
    initial begin
        scl = 1'b1;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // Pull-up: a line nobody pulls reads high, never a stale value.
    assign sda = ~(sda_pull | sda_oe);
    // A received byte is flagged for one cycle only.
    always @(posedge core_clk) begin
        if (rx_valid) begin
            rx_valid <= 1'b0;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Data moves two cycles after the clock falls, so it never races the fall.
    task automatic bit_io(input logic b, output logic s);
        tick(2);
        sda_pull <= ~b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        s = sda;
        scl <= 1'b0;
    endtask
    task automatic start_cond;
        sda_pull <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
    endtask
    task automatic stop_cond;
        tick(2);
        sda_pull <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_pull <= 1'b0;
        tick(HALF);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(last, s);
    endtask
    // A refused address is tried again, but only up to the cap.
    task automatic open_xfer(input logic rd, output logic ok, output int tries);
        tries = 0;
        ok = 1'b0;
        while (!ok && tries < host_retry_cap) begin
            start_cond;
            send_byte({ADDR, rd}, ok);
            tries++;
            if (!ok) begin
                stop_cond;
            end
        end
    endtask
    // The first byte is the pointer; the rest land from there onward.
    task automatic write_bytes(input logic [7:0] bytes[$], output logic ok, output int tries);
        logic a;
        open_xfer(1'b0, ok, tries);
        if (ok) begin
            foreach (bytes[i]) begin
                send_byte(bytes[i], a);
            end
            stop_cond;
        end
        tick(SCAN_GAP);
    endtask
    task automatic read_bytes(input int n, input logic set_ptr, output logic ok);
        logic [7:0] b;
        int tries;
        if (set_ptr) begin
            write_bytes('{8'h00}, ok, tries);
        end
        open_xfer(1'b1, ok, tries);
        if (ok) begin
            for (int i = 0; i < n; i++) begin
                recv_byte(i == n - 1, b);
                rx_byte <= b;
                rx_valid <= 1'b1;
            end
            stop_cond;
        end
    endtask
endmodule // host_i2c_model
`default_nettype wire

/* File: test/touch_ctrl_i2c_config_access_tb.sv */
`include "touch_cfg_params.svh"
`default_nettype none
// ==========
// Bench: host model on the serial side, bus tasks on the register side.
module touch_ctrl_i2c_config_access_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic scl, sda, sda_out, sda_oe, avs_waitrequest, swrst_busy, rx_valid;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic [9:0] touch_in = 10'h000;
    logic [7:0] diag_in = 8'h00;
    logic [9:0] led_out;
    logic [7:0] host_out, rx_byte;
    touch_cfg_pkg::led_eff_s eff_out;
    logic [31:0] av_q[$];
    logic [7:0] rx_q[$];
    logic [11:0] cases [4] = '{12'h001, 12'hF01, 12'h0F1, 12'h000};
    int bad_count = 0;
    int cmp_count = 0;
    always #10 core_clk = ~core_clk;
    // A short reset time keeps the busy window within reach of retries.
    touch_ctrl_i2c_config_access #(.SWRST_CYCLES(400)) uut (
        .core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .touch_in(touch_in), .diag_in(diag_in), .led_out(led_out),
        .host_out(host_out), .eff_out(eff_out), .swrst_busy(swrst_busy));
    host_i2c_model host (
        .core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda),
        .rx_valid(rx_valid), .rx_byte(rx_byte));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge.
    task automatic av_access(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h000000, d};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic av_read(input logic [5:0] idx, input logic [7:0] exp);
        av_q.push_back({24'h000000, exp});
        av_access(1'b0, idx, 8'h00);
    endtask
    // ==========
    // Watcher: each result that appears is matched to the oldest note.
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            check("avs_readdata", av_q.pop_front(), avs_readdata);
        end
        if (rx_valid === 1'b1) begin
            check("i2c_byte", {24'h000000, rx_q.pop_front()}, {24'h000000, rx_byte});
        end
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Roughly ten thousand cycles are needed; a hang ends well after that.
    initial begin
        repeat (60000) @(posedge core_clk);
        bad_count++;
        end_of_test;
    end
    // ==========
    // Main sequence.
    initial begin
        logic ok;
        int tries;
        logic [3:0] t, b, l, o;
        logic [7:0] v;
        logic [9:0] tv;
        void'($urandom(75));
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 6; i++) begin
            av_read(i[5:0], 8'h00);
        end
        av_read(6'h20, 8'h00);
        host.write_bytes('{8'h01, 8'hA5}, ok, tries);
        check("setup_ack", 32'h00000001, {31'h0, ok});
        // Automatic threshold goes off ahead of the explicit finger threshold.
        host.write_bytes('{8'h06, 8'h00, 8'h5C}, ok, tries);
        av_read(6'h07, 8'h5C);
        // Mode settings are all done before any mode change.
        for (int k = 0; k < 4; k++) begin
            {t, b, l} = cases[k];
            // Top bit kept set so the serial read-back sees a nonzero byte.
            o = 4'($urandom) | 4'h8;
            // Enables go ahead of the on-time detail.
            host.write_bytes('{8'h02, {4'h0, t}, {4'h0, b}, {4'h0, l}, {4'h0, o}}, ok, tries);
            av_read(6'h02, {4'h0, t});
            av_read(6'h03, {4'h0, b});
            av_read(6'h04, {4'h0, l});
            av_read(6'h05, {4'h0, o});
            check("eff_out", {27'h0, o & ~(t | b), l[0] & ~(|t)}, {27'h0, eff_out});
        end
        // Pointer is left at 0x06, yet the read starts at zero.
        rx_q = '{8'h00, 8'hA5, {4'h0, t}, {4'h0, b}, {4'h0, l}, {4'h0, o}};
        host.read_bytes(6, 1'b0, ok);
        rx_q.push_back(8'h00);
        rx_q.push_back(8'hA5);
        host.read_bytes(2, 1'b1, ok);
        for (int g = 0; g < 3; g++) begin
            v = 8'($urandom);
            host.write_bytes('{8'(8'h12 + 3 * g), v}, ok, tries);
            for (int m = 0; m < 3; m++) begin
                av_read(6'(6'h11 + 3 * g + m), v);
            end
        end
        av_read(6'h10, 8'h00);
        tv = 10'($urandom);
        v = 8'($urandom);
        touch_in <= tv;
        diag_in <= v;
        repeat (3) @(posedge core_clk);
        // Toggle and last-button are off here, so the drive follows touch.
        check("led_out", {22'h0, tv}, {22'h0, led_out});
        check("sda_out", 32'h00000000, {31'h0, sda_out});
        av_read(6'h1A, tv[7:0]);
        av_read(6'h1B, {6'h00, tv[9:8]});
        av_read(6'h1C, tv[7:0]);
        av_read(6'h1E, v);
        av_access(1'b1, 6'h1A, 8'hFF);
        av_read(6'h1A, tv[7:0]);
        touch_in <= 10'h000;
        av_access(1'b1, 6'h1C, 8'hFF);
        av_access(1'b1, 6'h1D, 8'hFF);
        av_read(6'h1C, 8'h00);
        av_read(6'h1D, 8'h00);
        // Top bit kept set so the clear at the end of the reset is visible.
        v = 8'($urandom) | 8'h80;
        av_access(1'b1, 6'h1F, v);
        repeat (2) @(posedge core_clk);
        check("host_out", {24'h0, v}, {24'h0, host_out});
        host.write_bytes('{8'h00, `SAVE_CMD}, ok, tries);
        check("swrst_busy", 32'h00000001, {31'h0, swrst_busy});
        // The device refuses while busy, so this write needs retries.
        host.write_bytes('{8'h02, 8'h05}, ok, tries);
        check("retried", 32'h00000001, {31'h0, tries > 1});
        check("write_ack", 32'h00000001, {31'h0, ok});
        check("host_out", 32'h00000000, {24'h0, host_out});
        av_read(6'h00, 8'h00);
        av_read(6'h02, 8'h05);
        repeat (2) @(posedge core_clk);
        end_of_test;
    end
endmodule // touch_ctrl_i2c_config_access_tb
`default_nettype wire
